// File: logic/sfc_pkg.sv
// Shared constants for the semaphore flag host controller
package sfc_pkg;
  localparam int          FLAG_COUNT  = 8;              // Independent flags in the bank
  localparam int          IDX_W       = 3;              // Width of the flag index lines
  localparam int          DATA_W      = 16;             // Width of the data pins
  localparam int          CLK_MHZ     = 40;             // Rate of ref_clk
  localparam int          T_ACC_NS    = 25;             // Flag read access time
  localparam int          T_WP_NS     = 25;             // Flag write pulse width
  localparam int          SYNC_STAGES = 2;              // Flip-flops on the data inputs
  // Least times round up, never below one cycle
  localparam int          ACC_CYC_RAW = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int          WP_CYC_RAW  = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int          ACC_CYC     = (ACC_CYC_RAW < 1) ? 1 : ACC_CYC_RAW;
  localparam int          WP_CYC      = (WP_CYC_RAW < 1) ? 1 : WP_CYC_RAW;
  localparam int          CNT_W       = 4;              // Width of the pin cycle counter
  localparam logic        FLAG_TAKE   = 1'b0;           // Request value that asks for the token
  localparam logic        FLAG_FREE   = 1'b1;           // Request value that gives it back
  localparam int          POLL_W      = 4;              // Width of the poll counter
  localparam logic [3:0]  POLL_DEF    = 4'h3;           // Default reads after a failed claim

  // User commands
  typedef enum logic {
    SFC_OP_CLAIM,
    SFC_OP_RELEASE
  } sfc_op_t;
endpackage

// File: logic/sfc_cyc_if.sv
`timescale 1ns/1ps
// One flag bus cycle, from the sequencer to the pin driver
interface sfc_cyc_if;
  import sfc_pkg::*;
  logic             req;    // Start a cycle, one-cycle pulse
  logic             wr;     // High for a write cycle
  logic [IDX_W-1:0] idx;    // Flag being accessed
  logic             wbit;   // Request value for a write
  logic             done;   // Cycle finished, one-cycle pulse
  logic             rflag;  // Flag value read, valid with done

  modport master (output req, output wr, output idx, output wbit, input done, input rflag);
  modport slave  (input req, input wr, input idx, input wbit, output done, output rflag);
endinterface

// File: logic/sfc_pin_cycle.sv
`timescale 1ns/1ps
// Drives one flag read or write cycle on the device pins
module sfc_pin_cycle
  import sfc_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Sequencer side
  sfc_cyc_if.slave               cyc,
  // Device pins
  output logic                   flag_bank_select_n,
  output logic [IDX_W-1:0]       flag_index_lines,
  output logic                   rw_n,
  output logic                   oe_n,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_n
);
  typedef enum logic [1:0] {PC_IDLE, PC_WRITE, PC_READ, PC_RECOV} sfc_pc_state_t;

  sfc_pc_state_t     state_q;   // Pin cycle state
  logic [CNT_W-1:0]  cnt_q;     // Cycles left in the phase
  logic [DATA_W-1:0] sync1_q;   // First data synchroniser stage
  logic [DATA_W-1:0] sync2_q;   // Second stage, the only one read
  logic              rflag_q;   // Captured flag value

  // Data pins come from the other clock world
  always_ff @(posedge ref_clk) begin
    sync1_q <= data_in;
    sync2_q <= sync1_q;
  end

  // Pin cycle sequencing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q            <= PC_IDLE;
      cnt_q              <= '0;
      flag_bank_select_n <= 1'b1;
      flag_index_lines   <= '0;
      rw_n               <= 1'b1;
      oe_n               <= 1'b1;
      data_out           <= '0;
      data_oe_n          <= 1'b1;
      rflag_q            <= 1'b1;
    end else begin
      case (state_q)
        PC_IDLE: begin
          if (cyc.req) begin
            // Index only, higher address lines do not exist here
            flag_index_lines   <= cyc.idx;
            flag_bank_select_n <= 1'b0;
            if (cyc.wr) begin
              // Request value on every bit, the device uses bit zero
              data_out  <= {DATA_W{cyc.wbit}};
              data_oe_n <= 1'b0;
              rw_n      <= 1'b0;
              cnt_q     <= CNT_W'(WP_CYC);
              state_q   <= PC_WRITE;
            end else begin
              // Data arrives through the synchroniser, so wait longer
              oe_n    <= 1'b0;
              cnt_q   <= CNT_W'(ACC_CYC + SYNC_STAGES);
              state_q <= PC_READ;
            end
          end
        end
        PC_WRITE: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == CNT_W'(1)) begin
            rw_n               <= 1'b1;
            flag_bank_select_n <= 1'b1;
            state_q            <= PC_RECOV;
          end
        end
        PC_READ: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == CNT_W'(1)) begin
            // Flag is replicated; any low bit counts as owned
            rflag_q            <= &sync2_q;
            // Dropping select and enable lets the next read see a fresh value
            oe_n               <= 1'b1;
            flag_bank_select_n <= 1'b1;
            state_q            <= PC_RECOV;
          end
        end
        PC_RECOV: begin
          // Data released a cycle after the strobes to avoid a hold hazard
          data_oe_n <= 1'b1;
          state_q   <= PC_IDLE;
        end
        default: state_q <= PC_IDLE;
      endcase
    end
  end

  // Completion handshake
  assign cyc.done  = (state_q == PC_RECOV);
  assign cyc.rflag = rflag_q;

  // Index held steady for the whole select window
  property p_idx_stable;
    @(posedge ref_clk) disable iff (rst)
      (!flag_bank_select_n && $past(!flag_bank_select_n)) |-> $stable(flag_index_lines);
  endproperty
  a_idx_stable: assert property (p_idx_stable) else $error("Flag index moved while selected");

  // Write pulse only inside select with data driven
  property p_write_framed;
    @(posedge ref_clk) disable iff (rst)
      !rw_n |-> (!flag_bank_select_n && !data_oe_n && oe_n);
  endproperty
  a_write_framed: assert property (p_write_framed) else $error("Write pulse outside flag select");
endmodule

// File: logic/sfc_host.sv
`timescale 1ns/1ps
// Function
// - Claim by writing zero, then reading back
// - After failure, poll or write one
// - Release unneeded flag by writing one
// - Write one to every flag at start
// - Select strobe with three-bit index
module sfc_host
  import sfc_pkg::*;
#(
  parameter logic [POLL_W-1:0] POLL_LIMIT = POLL_DEF  // Extra reads before withdrawing
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // User command port
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire sfc_pkg::sfc_op_t       cmd_op,
  input  wire logic [sfc_pkg::IDX_W-1:0] cmd_idx,
  output logic                        rsp_valid,
  output logic                        rsp_granted,
  output logic [sfc_pkg::FLAG_COUNT-1:0] flags_held,
  // Device flag pins
  output logic                        flag_bank_select_n,
  output logic [sfc_pkg::IDX_W-1:0]   flag_index_lines,
  output logic                        rw_n,
  output logic                        oe_n,
  input  wire logic [sfc_pkg::DATA_W-1:0] data_in,
  output logic [sfc_pkg::DATA_W-1:0]  data_out,
  output logic                        data_oe_n
);
  import sfc_pkg::*;

  typedef enum logic [3:0] {
    S_INIT, S_INIT_W, S_IDLE, S_CLM_WR, S_CLM_WR_W, S_CLM_RD, S_CLM_RD_W,
    S_WDRAW, S_WDRAW_W, S_REL, S_REL_W
  } sfc_state_t;

  sfc_state_t              state_q;     // Sequencer state
  logic [IDX_W-1:0]        idx_q;       // Flag in work
  logic [POLL_W-1:0]       polls_q;     // Reads left after a failed claim
  logic [FLAG_COUNT-1:0]   held_q;      // Flags this side owns
  logic                    rsp_valid_q; // Answer strobe
  logic                    rsp_grant_q; // Answer value
  logic                    init_done_q; // Start-up release finished
  logic [IDX_W:0]          ones_cnt_q;  // Start-up writes of one seen
  logic                    last_wval_q; // Last written request value
  logic [IDX_W-1:0]        last_widx_q; // Last written flag

  sfc_cyc_if cyc ();

  // Pin driver for one cycle at a time
  sfc_pin_cycle u_pins (
    .ref_clk            (ref_clk),
    .rst                (rst),
    .cyc                (cyc.slave),
    .flag_bank_select_n (flag_bank_select_n),
    .flag_index_lines   (flag_index_lines),
    .rw_n               (rw_n),
    .oe_n               (oe_n),
    .data_in            (data_in),
    .data_out           (data_out),
    .data_oe_n          (data_oe_n)
  );

  // Bus cycle requests follow the issue states
  always_comb begin
    cyc.req  = 1'b0;
    cyc.wr   = 1'b1;
    cyc.wbit = FLAG_FREE;
    cyc.idx  = idx_q;
    case (state_q)
      S_INIT, S_WDRAW, S_REL: begin
        cyc.req = 1'b1;
      end
      S_CLM_WR: begin
        // Write the request first so no gap exists between test and set
        cyc.req  = 1'b1;
        cyc.wbit = FLAG_TAKE;
      end
      S_CLM_RD: begin
        cyc.req = 1'b1;
        cyc.wr  = 1'b0;
      end
      default: cyc.req = 1'b0;
    endcase
  end

  // Command sequencing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= S_INIT;
      idx_q   <= '0;
      polls_q <= '0;
    end else begin
      case (state_q)
        // The device latches power up unknown, so free all of them
        S_INIT: state_q <= S_INIT_W;
        S_INIT_W: begin
          if (cyc.done) begin
            idx_q   <= idx_q + 1'b1;
            state_q <= (idx_q == IDX_W'(FLAG_COUNT - 1)) ? S_IDLE : S_INIT;
          end
        end
        S_IDLE: begin
          if (cmd_valid) begin
            idx_q   <= cmd_idx;
            polls_q <= POLL_LIMIT;
            state_q <= (cmd_op == SFC_OP_CLAIM) ? S_CLM_WR : S_REL;
          end
        end
        S_CLM_WR:   state_q <= S_CLM_WR_W;
        S_CLM_WR_W: if (cyc.done) state_q <= S_CLM_RD;
        S_CLM_RD:   state_q <= S_CLM_RD_W;
        S_CLM_RD_W: begin
          if (cyc.done) begin
            if (cyc.rflag == FLAG_TAKE) begin
              state_q <= S_IDLE;
            end else if (polls_q != '0) begin
              // Lost so far; our pending zero may still be handed over
              polls_q <= polls_q - 1'b1;
              state_q <= S_CLM_RD;
            end else begin
              // Give up and withdraw so the request does not linger
              state_q <= S_WDRAW;
            end
          end
        end
        S_WDRAW:   state_q <= S_WDRAW_W;
        S_WDRAW_W: if (cyc.done) state_q <= S_IDLE;
        S_REL:     state_q <= S_REL_W;
        S_REL_W:   if (cyc.done) state_q <= S_IDLE;
        default:   state_q <= S_INIT;
      endcase
    end
  end

  // Answers and ownership record
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_grant_q <= 1'b0;
      held_q      <= '0;
    end else begin
      rsp_valid_q <= 1'b0;
      if (state_q == S_CLM_RD_W && cyc.done && cyc.rflag == FLAG_TAKE) begin
        rsp_valid_q   <= 1'b1;
        rsp_grant_q   <= 1'b1;
        held_q[idx_q] <= 1'b1;
      end
      if (cyc.done && (state_q == S_WDRAW_W || state_q == S_REL_W)) begin
        rsp_valid_q   <= 1'b1;
        rsp_grant_q   <= 1'b0;
        held_q[idx_q] <= 1'b0;
      end
    end
  end

  // Start-up progress, watched by the start-up check
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      init_done_q <= 1'b0;
      ones_cnt_q  <= '0;
    end else begin
      if (state_q == S_INIT) ones_cnt_q <= ones_cnt_q + 1'b1;
      if (state_q == S_IDLE) init_done_q <= 1'b1;
    end
  end

  // Last write seen, for checking the claim order
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_wval_q <= FLAG_FREE;
      last_widx_q <= '0;
    end else if (cyc.req && cyc.wr) begin
      last_wval_q <= cyc.wbit;
      last_widx_q <= cyc.idx;
    end
  end

  assign cmd_ready   = (state_q == S_IDLE);
  assign rsp_valid   = rsp_valid_q;
  assign rsp_granted = rsp_grant_q;
  assign flags_held  = held_q;

  // A claim read always follows a zero write to the same flag
  property p_write_before_read;
    @(posedge ref_clk) disable iff (rst)
      (cyc.req && !cyc.wr) |-> (last_wval_q == FLAG_TAKE && last_widx_q == cyc.idx);
  endproperty
  a_write_before_read: assert property (p_write_before_read) else $error("Claim read without prior zero write");

  // Exhausted failure leads to a write of one to the same flag
  property p_withdraw;
    @(posedge ref_clk) disable iff (rst)
      (state_q == S_CLM_RD_W && cyc.done && cyc.rflag && polls_q == '0)
        |-> ##1 (cyc.req && cyc.wr && cyc.wbit == FLAG_FREE && cyc.idx == $past(idx_q));
  endproperty
  a_withdraw: assert property (p_withdraw) else $error("Failed claim not withdrawn");

  // Release command writes one within a bounded time and clears ownership
  property p_release;
    @(posedge ref_clk) disable iff (rst)
      (cmd_valid && cmd_ready && cmd_op == SFC_OP_RELEASE)
        |-> ##1 (cyc.req && cyc.wr && cyc.wbit == FLAG_FREE) ##[1:12] (rsp_valid && !flags_held[idx_q]);
  endproperty
  a_release: assert property (p_release) else $error("Release did not free the flag");

  // Commands open only after every flag got a one
  property p_init_all;
    @(posedge ref_clk) disable iff (rst)
      $rose(init_done_q) |-> (ones_cnt_q == (IDX_W+1)'(FLAG_COUNT));
  endproperty
  a_init_all: assert property (p_init_all) else $error("Start-up release incomplete");

  // Ownership only after a zero readback
  property p_grant_cause;
    @(posedge ref_clk) disable iff (rst)
      (rsp_valid && rsp_granted) |-> $past(cyc.done && cyc.rflag == FLAG_TAKE);
  endproperty
  a_grant_cause: assert property (p_grant_cause) else $error("Grant without zero readback");

  c_grant:    cover property (@(posedge ref_clk) disable iff (rst) rsp_valid && rsp_granted);
  c_withdraw: cover property (@(posedge ref_clk) disable iff (rst) state_q == S_WDRAW);
  c_retry:    cover property (@(posedge ref_clk) disable iff (rst)
                              state_q == S_CLM_RD && $past(state_q) == S_CLM_RD_W);
  c_release:  cover property (@(posedge ref_clk) disable iff (rst) state_q == S_REL_W && cyc.done);
endmodule

// File: verification/sfc_dev_model.sv
`timescale 1ns/1ps
// Behavioural flag bank: host pins on the left, bench drives the right side
module sfc_dev_model
  import sfc_pkg::*;
(
  // Clock
  input  wire logic              ref_clk,
  // Left side pins from the host
  input  wire logic              flag_bank_select_n,
  input  wire logic [IDX_W-1:0]  flag_index_lines,
  input  wire logic              rw_n,
  input  wire logic              oe_n,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe_n,
  output logic [DATA_W-1:0]      data_in,
  // Right side, one write per cycle from the bench
  input  wire logic              r_we,
  input  wire logic [IDX_W-1:0]  r_idx,
  input  wire logic              r_bit,
  output logic [FLAG_COUNT-1:0]  r_flag
);
  logic [FLAG_COUNT-1:0] req_l;   // Left request latches
  logic [FLAG_COUNT-1:0] req_r;   // Right request latches
  logic [FLAG_COUNT-1:0] own_l;   // Left holds the token
  logic [FLAG_COUNT-1:0] own_r;   // Right holds the token
  logic                  rd_val;  // Left output latch
  logic [DATA_W-1:0]     last_q;  // Last value shown on the bus
  logic                  drv;     // Device drives the left data pins

  // Power-up state left dirty on purpose: left owns everything
  // No latch reset pin, so only the start-up writes clean up
  initial begin
    req_l  = '0;
    own_l  = '1;
    req_r  = '1;
    own_r  = '0;
    rd_val = 1'b1;
    last_q = '0;
  end

  // Request latches, left first so same-cycle ties go left
  always @(posedge ref_clk) begin
    if (!flag_bank_select_n && !rw_n) begin
      req_l[flag_index_lines] = data_out[0];
    end
    if (r_we) begin
      req_r[r_idx] = r_bit;
    end
    for (int i = 0; i < FLAG_COUNT; i++) begin
      if (own_l[i] && req_l[i]) begin
        own_l[i] = 1'b0;
      end
      if (own_r[i] && req_r[i]) begin
        own_r[i] = 1'b0;
      end
      // Owner only from the two latches; pending zero takes over at once
      if (!own_l[i] && !own_r[i]) begin
        if (!req_l[i]) begin
          own_l[i] = 1'b1;
        end else if (!req_r[i]) begin
          own_r[i] = 1'b1;
        end
      end
    end
  end

  // Read value frozen while select and enable stay low
  always @(flag_bank_select_n or oe_n) begin
    if (!flag_bank_select_n && !oe_n) begin
      rd_val = !own_l[flag_index_lines];
    end
  end

  // Released bus shows the inverse of its last value, never a stale copy
  assign drv     = !flag_bank_select_n && !oe_n && rw_n && data_oe_n;
  assign data_in = drv ? {DATA_W{rd_val}} : ~last_q;
  assign r_flag  = ~own_r;

  // Remember what the bus carried
  always @(posedge ref_clk) begin
    if (drv) begin
      last_q <= data_in;
    end
  end
endmodule

// File: verification/dual_port_semaphore_flags_tb_top.sv
`timescale 1ns/1ps
// Bench for the flag host controller against the flag bank model
module dual_port_semaphore_flags_tb_top;
  import sfc_pkg::*;
  localparam int LIMIT = 20000;  // Cycle ceiling, whole run needs far less

  logic                  ref_clk   = 1'b0;
  logic                  rst       = 1'b1;
  logic                  cmd_valid = 1'b0;
  logic                  cmd_ready;
  sfc_op_t               cmd_op    = SFC_OP_CLAIM;
  logic [IDX_W-1:0]      cmd_idx   = '0;
  logic                  rsp_valid;
  logic                  rsp_granted;
  logic [FLAG_COUNT-1:0] flags_held;
  logic                  flag_bank_select_n;
  logic [IDX_W-1:0]      flag_index_lines;
  logic                  rw_n;
  logic                  oe_n;
  logic [DATA_W-1:0]     data_in;
  logic [DATA_W-1:0]     data_out;
  logic                  data_oe_n;
  logic                  r_we      = 1'b0;
  logic [IDX_W-1:0]      r_idx     = '0;
  logic                  r_bit     = 1'b1;
  logic [FLAG_COUNT-1:0] r_flag;
  logic                  g;
  int                    n_errors  = 0;
  int                    n_checks  = 0;
  int                    cyc_cnt   = 0;

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  sfc_host #(.POLL_LIMIT(4'h3)) i_sfc_host (
    .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_idx(cmd_idx), .rsp_valid(rsp_valid), .rsp_granted(rsp_granted), .flags_held(flags_held),
    .flag_bank_select_n(flag_bank_select_n), .flag_index_lines(flag_index_lines), .rw_n(rw_n),
    .oe_n(oe_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

  sfc_dev_model i_sfc_dev_model (
    .ref_clk(ref_clk), .flag_bank_select_n(flag_bank_select_n), .flag_index_lines(flag_index_lines),
    .rw_n(rw_n), .oe_n(oe_n), .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in),
    .r_we(r_we), .r_idx(r_idx), .r_bit(r_bit), .r_flag(r_flag));

  // Verdict and end of run
  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      n_errors++;
      stop_test();
    end
  end

  // Single-bit compare
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Flag vector compare
  task automatic chk_vec(input logic [FLAG_COUNT-1:0] got, input logic [FLAG_COUNT-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One command; valid held until taken, answer awaited under a bound
  task automatic run_cmd(input sfc_op_t op, input logic [IDX_W-1:0] idx, output logic gr);
    int k;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_idx   <= idx;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 200);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (rsp_valid !== 1'b1 && k < 200);
    chk_bit(rsp_valid, 1'b1);
    gr = rsp_granted;
  endtask

  // Right processor writes one flag, then lets the result settle
  task automatic r_write(input logic [IDX_W-1:0] idx, input logic b);
    @(posedge ref_clk);
    r_we  <= 1'b1;
    r_idx <= idx;
    r_bit <= b;
    @(posedge ref_clk);
    r_we <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Start-up: both sides free every flag
  task automatic t_init();
    int k;
    for (int i = 0; i < FLAG_COUNT; i++) begin
      r_write(i[IDX_W-1:0], 1'b1);
    end
    k = 0;
    while (cmd_ready !== 1'b1 && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    chk_bit(cmd_ready, 1'b1);
    chk_vec(flags_held, 8'h00);
    chk_vec(r_flag, 8'hff);
  endtask

  // Claim every flag, then release every flag
  task automatic t_all();
    logic [FLAG_COUNT-1:0] exp;
    exp = '0;
    for (int i = 0; i < FLAG_COUNT; i++) begin
      run_cmd(SFC_OP_CLAIM, i[IDX_W-1:0], g);
      exp[i] = 1'b1;
      chk_bit(g, 1'b1);
      chk_vec(flags_held, exp);
    end
    r_write(3'h7, 1'b0);
    chk_vec(r_flag, 8'hff);
    r_write(3'h7, 1'b1);
    for (int i = 0; i < FLAG_COUNT; i++) begin
      run_cmd(SFC_OP_RELEASE, i[IDX_W-1:0], g);
      exp[i] = 1'b0;
      chk_vec(flags_held, exp);
    end
    r_write(3'h7, 1'b0);
    chk_bit(r_flag[7], 1'b0);
    r_write(3'h7, 1'b1);
  endtask

  // Right holds flag 2; left gives up and withdraws
  task automatic t_lost();
    r_write(3'h2, 1'b0);
    run_cmd(SFC_OP_CLAIM, 3'h2, g);
    chk_bit(g, 1'b0);
    chk_bit(flags_held[2], 1'b0);
    chk_bit(r_flag[2], 1'b0);
    r_write(3'h2, 1'b1);
    chk_bit(r_flag[2], 1'b1);
  endtask

  // Right releases flag 3 while left polls; pending left request wins
  task automatic t_takeover();
    r_write(3'h3, 1'b0);
    fork
      run_cmd(SFC_OP_CLAIM, 3'h3, g);
      begin
        repeat (8) @(posedge ref_clk);
        r_write(3'h3, 1'b1);
      end
    join
    chk_bit(g, 1'b1);
    chk_bit(flags_held[3], 1'b1);
    r_write(3'h3, 1'b0);
    chk_bit(r_flag[3], 1'b1);
    r_write(3'h3, 1'b1);
    run_cmd(SFC_OP_RELEASE, 3'h3, g);
    chk_bit(flags_held[3], 1'b0);
  endtask

  // Both sides write zero to flag 5 at the same edge
  task automatic t_tie();
    fork
      run_cmd(SFC_OP_CLAIM, 3'h5, g);
      begin
        @(negedge flag_bank_select_n);
        r_we  <= 1'b1;
        r_idx <= 3'h5;
        r_bit <= 1'b0;
        @(posedge ref_clk);
        r_we <= 1'b0;
      end
    join
    chk_bit(g, 1'b1);
    chk_bit(r_flag[5], 1'b1);
    r_write(3'h5, 1'b1);
    run_cmd(SFC_OP_RELEASE, 3'h5, g);
    chk_vec(r_flag, 8'hff);
  endtask

  // Reset in mid-run with flag 1 held; the start-up writes must free it again
  task automatic t_reset();
    int k;
    run_cmd(SFC_OP_CLAIM, 3'h1, g);
    chk_bit(g, 1'b1);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk_bit(cmd_ready, 1'b0);
    chk_vec(flags_held, 8'h00);
    rst <= 1'b0;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    chk_bit(cmd_ready, 1'b1);
    // Stale left claim is gone only if flag 1 got its one
    r_write(3'h1, 1'b0);
    chk_bit(r_flag[1], 1'b0);
    r_write(3'h1, 1'b1);
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_init();
    t_all();
    t_lost();
    t_takeover();
    t_tie();
    t_reset();
    stop_test();
  end
endmodule
